// ### rtl/rx_port_status_flags.sv
// Notes on behaviour
// - Parity flag set while count exceeds limit
// - Parity flag clears only with count registers
// - Bit 1 shows live pass indication
// - Bit 0 shows current receiver lock
// - Unequal line lengths in frame set bit 7
// - Unstable flag holds until register read
// - Line length change sets bit 6
// - Link encoding error sets bit 5
// - Packet buffer overflow sets bit 4
// - Bit 3 mirrors camera receive error
// - Low input frequency sets no-clock bit
// - Line count change sets bit 0
// - Lock change flagged until first register read
// - Separate copy per port, selected by host
`timescale 1ns/1ps
`default_nettype none
`include "rx_status_params.svh"

module rx_port_status_flags
	import rx_status_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         reset_n,
	input  wire port_idx_t    port_select,
	input  wire logic         rd_strobe,
	input  wire logic [7:0]   rd_addr,
	input  wire port_vec_t    receiver_locked,
	input  wire port_vec_t    pass_ok,
	input  wire port_vec_t    parity_over,
	input  wire port_vec_t    parity_clear,
	input  wire port_vec_t    unstable_evt,
	input  wire port_vec_t    len_chg_evt,
	input  wire port_vec_t    encode_err_evt,
	input  wire port_vec_t    buf_overflow_evt,
	input  wire port_vec_t    camera_err,
	input  wire port_vec_t    frequency_stable_flag,
	input  wire port_vec_t    freq_below_limit,
	input  wire port_vec_t    cnt_chg_evt,
	input  wire port_vec_t    crc_err_evt,
	input  wire port_vec_t    seq_err_evt,
	output var  status_byte_t rd_data_r,
	output var  logic         rd_valid_r
);

	flag_low_t    one_all [NUM_PORTS];
	status_byte_t two_all [NUM_PORTS];
	port_vec_t    clear_one;
	port_vec_t    clear_two;
	logic         hit_one;
	logic         hit_two;
	status_byte_t rd_data_nxt;
	logic         rd_valid_nxt;

	// Address decode of the paged status pair
	assign hit_one = rd_strobe && (rd_addr == `STS_ONE_OFS);
	assign hit_two = rd_strobe && (rd_addr == `STS_TWO_OFS);

	// Clear pulses reach only the port the host is looking at
	always_comb begin
		clear_one = '0;
		clear_two = '0;
		clear_one[port_select] = hit_one;
		clear_two[port_select] = hit_two;
	end

	// One flag bank per receive port
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			port_flag_bank u_bank (
				.mclk             (mclk),
				.reset_n          (reset_n),
				.receiver_locked  (receiver_locked[p]),
				.pass_ok          (pass_ok[p]),
				.parity_over      (parity_over[p]),
				.parity_clear     (parity_clear[p]),
				.unstable_evt     (unstable_evt[p]),
				.len_chg_evt      (len_chg_evt[p]),
				.encode_err_evt   (encode_err_evt[p]),
				.buf_overflow_evt (buf_overflow_evt[p]),
				.camera_err       (camera_err[p]),
				.frequency_stable_flag      (frequency_stable_flag[p]),
				.freq_below_limit (freq_below_limit[p]),
				.cnt_chg_evt      (cnt_chg_evt[p]),
				.crc_err_evt      (crc_err_evt[p]),
				.seq_err_evt      (seq_err_evt[p]),
				.clear_one        (clear_one[p]),
				.clear_two        (clear_two[p]),
				.status_one       (one_all[p]),
				.status_two       (two_all[p])
			);
		end
	endgenerate

	// Read data: the value returned is exactly the value being cleared
	always_comb begin
		rd_data_nxt  = rd_data_r;
		rd_valid_nxt = rd_strobe;
		if (hit_one)
			rd_data_nxt = {port_select, one_all[port_select]};
		else if (hit_two)
			rd_data_nxt = two_all[port_select];
		else if (rd_strobe)
			rd_data_nxt = `STS_RESET; // Other offsets belong elsewhere
	end

	// Read answer registers; data holds until the next read
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_r  <= `STS_RESET;
			rd_valid_r <= 1'b0;
		end else begin
			rd_data_r  <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
		end
	end

	// Helpers for the checks below
	logic sel_locked;
	logic sel_pass;
	logic sel_camera;
	logic sel_overflow;
	assign sel_locked   = receiver_locked[port_select];
	assign sel_pass     = pass_ok[port_select];
	assign sel_camera   = camera_err[port_select];
	assign sel_overflow = buf_overflow_evt[port_select];
	logic sel_unstable;
	logic sel_len_chg;
	logic sel_encode;
	logic sel_cnt_chg;
	logic sel_below;
	logic sel_freq;
	logic sel_parity;
	assign sel_unstable = unstable_evt[port_select];
	assign sel_len_chg  = len_chg_evt[port_select];
	assign sel_encode   = encode_err_evt[port_select];
	assign sel_cnt_chg  = cnt_chg_evt[port_select];
	assign sel_below    = freq_below_limit[port_select];
	assign sel_freq     = frequency_stable_flag[port_select];
	assign sel_parity   = parity_over[port_select];

	// Port held and reset gone, so the held level bits saw real inputs
	sequence read_one_s;
		hit_one && $stable(port_select) && $past(reset_n);
	endsequence

	sequence read_two_s;
		hit_two && $stable(port_select) && $past(reset_n);
	endsequence

	// Event on the shown port, then a read of the second register
	sequence seen_then_two_s(ev);
		ev ##1 read_two_s;
	endsequence

	lock_bit_a: assert property (@(posedge mclk) disable iff (!reset_n)
		read_one_s |=> rd_data_r[`ONE_LOCK] == $past(sel_locked, 2))
		else $error("lock bit does not follow receiver");

	pass_bit_a: assert property (@(posedge mclk) disable iff (!reset_n)
		read_one_s |=> rd_data_r[`ONE_PASS] == $past(sel_pass, 2))
		else $error("pass bit does not follow receiver");

	port_num_a: assert property (@(posedge mclk) disable iff (!reset_n)
		hit_one |=> rd_data_r[7:6] == $past(port_select))
		else $error("port number field wrong");

	camera_bit_a: assert property (@(posedge mclk) disable iff (!reset_n)
		read_two_s |=> rd_data_r[`TWO_CAMERA_ERR] == $past(sel_camera, 2))
		else $error("camera error bit wrong");

	overflow_seen_a: assert property (@(posedge mclk) disable iff (!reset_n)
		sel_overflow ##1 (read_two_s and !$changed(port_select))
		|=> rd_data_r[`TWO_BUF_ERR])
		else $error("buffer overflow not reported");

	read_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
		read_two_s ##1 (read_two_s and !$past(len_chg_evt[port_select]))
		|=> !rd_data_r[`TWO_LEN_CHG])
		else $error("length change flag survived its read");

	read_valid_a: assert property (@(posedge mclk) disable iff (!reset_n)
		rd_strobe |=> rd_valid_r ##1 (rd_valid_r == $past(rd_strobe)))
		else $error("read answer strobe misplaced");

	unmapped_a: assert property (@(posedge mclk) disable iff (!reset_n)
		rd_strobe && !hit_one && !hit_two |=> rd_data_r == `STS_RESET)
		else $error("unmapped read not zero");

	// Event flags must reach a read taken on the next edge
	unstable_seen_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		seen_then_two_s(sel_unstable) |=> rd_data_r[`TWO_LEN_UNSTABLE])
		else $error("unstable line length not reported");

	len_chg_seen_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		seen_then_two_s(sel_len_chg) |=> rd_data_r[`TWO_LEN_CHG])
		else $error("line length change not reported");

	encode_seen_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		seen_then_two_s(sel_encode) |=> rd_data_r[`TWO_ENCODE_ERR])
		else $error("encoding error not reported");

	count_seen_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		seen_then_two_s(sel_cnt_chg) |=> rd_data_r[`TWO_CNT_CHG])
		else $error("line count change not reported");

	no_clock_bit_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		read_two_s |=> rd_data_r[`TWO_NO_CLOCK] == $past(sel_below, 2))
		else $error("no-clock bit does not follow frequency");

	freq_bit_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		read_two_s |=> rd_data_r[`TWO_FREQUENCY_STABLE_FLAG] == $past(sel_freq, 2))
		else $error("frequency stable bit wrong");

	parity_seen_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		sel_parity ##1 read_one_s |=> rd_data_r[`ONE_PARITY])
		else $error("parity flag not reported");

	// Reset guard: the registered lock bit must have seen the old level
	lock_chg_seen_a: assert property (@(posedge mclk)
		disable iff (!reset_n)
		($changed(sel_locked) && $stable(port_select) && $past(reset_n))
		##1 read_one_s |=> rd_data_r[`ONE_LOCK_CHG])
		else $error("lock change not reported");

endmodule : rx_port_status_flags

`default_nettype wire

// ### rtl/rx_status_params.svh
`ifndef RX_STATUS_PARAMS_SVH
`define RX_STATUS_PARAMS_SVH

// Register offsets inside the per-port page
`define STS_ONE_OFS        8'h4d
`define STS_TWO_OFS        8'h4e
`define STS_RESET          8'h00

// First status register fields
`define ONE_PORT_NUM_HI    7
`define ONE_PORT_NUM_LO    6
`define ONE_CRC_ERR        5
`define ONE_LOCK_CHG       4
`define ONE_SEQ_ERR        3
`define ONE_PARITY         2
`define ONE_PASS           1
`define ONE_LOCK           0

// Second status register fields
`define TWO_LEN_UNSTABLE   7
`define TWO_LEN_CHG        6
`define TWO_ENCODE_ERR     5
`define TWO_BUF_ERR        4
`define TWO_CAMERA_ERR     3
`define TWO_FREQUENCY_STABLE_FLAG    2
`define TWO_NO_CLOCK       1
`define TWO_CNT_CHG        0

`endif

// ### rtl/rx_status_pkg.sv
package rx_status_pkg;
	localparam int NUM_PORTS = 4;
	typedef logic [7:0] status_byte_t;
	typedef logic [5:0] flag_low_t;
	typedef logic [1:0] port_idx_t;
	typedef logic [NUM_PORTS-1:0] port_vec_t;
endpackage : rx_status_pkg

// ### rtl/port_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "rx_status_params.svh"

module port_flag_bank
	import rx_status_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         reset_n,
	input  wire logic         receiver_locked,
	input  wire logic         pass_ok,
	input  wire logic         parity_over,
	input  wire logic         parity_clear,
	input  wire logic         unstable_evt,
	input  wire logic         len_chg_evt,
	input  wire logic         encode_err_evt,
	input  wire logic         buf_overflow_evt,
	input  wire logic         camera_err,
	input  wire logic         frequency_stable_flag,
	input  wire logic         freq_below_limit,
	input  wire logic         cnt_chg_evt,
	input  wire logic         crc_err_evt,
	input  wire logic         seq_err_evt,
	input  wire logic         clear_one,
	input  wire logic         clear_two,
	output var  flag_low_t    status_one,
	output var  status_byte_t status_two
);

	flag_low_t    one_r, one_nxt;
	status_byte_t two_r, two_nxt;

	// Clear-on-read drops only what was read; a same-cycle event survives
	always_comb begin
		one_nxt = one_r;
		two_nxt = two_r;
		one_nxt[`ONE_LOCK] = receiver_locked;
		one_nxt[`ONE_PASS] = pass_ok;
		// Set wins over the count-register clear
		if (parity_over)
			one_nxt[`ONE_PARITY] = 1'b1;
		else if (parity_clear)
			one_nxt[`ONE_PARITY] = 1'b0;
		one_nxt[`ONE_LOCK_CHG] = (receiver_locked != one_r[`ONE_LOCK])
			| (one_r[`ONE_LOCK_CHG] & ~clear_one);
		one_nxt[`ONE_CRC_ERR] = crc_err_evt
			| (one_r[`ONE_CRC_ERR] & ~clear_one);
		one_nxt[`ONE_SEQ_ERR] = seq_err_evt
			| (one_r[`ONE_SEQ_ERR] & ~clear_one);
		two_nxt[`TWO_LEN_UNSTABLE] = unstable_evt
			| (two_r[`TWO_LEN_UNSTABLE] & ~clear_two);
		two_nxt[`TWO_LEN_CHG] = len_chg_evt
			| (two_r[`TWO_LEN_CHG] & ~clear_two);
		two_nxt[`TWO_ENCODE_ERR] = encode_err_evt
			| (two_r[`TWO_ENCODE_ERR] & ~clear_two);
		two_nxt[`TWO_BUF_ERR] = buf_overflow_evt
			| (two_r[`TWO_BUF_ERR] & ~clear_two);
		two_nxt[`TWO_CAMERA_ERR] = camera_err;
		two_nxt[`TWO_FREQUENCY_STABLE_FLAG] = frequency_stable_flag;
		two_nxt[`TWO_NO_CLOCK] = freq_below_limit;
		two_nxt[`TWO_CNT_CHG] = cnt_chg_evt
			| (two_r[`TWO_CNT_CHG] & ~clear_two);
	end

	// Flag storage
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			one_r <= 6'h00;
			two_r <= `STS_RESET;
		end else begin
			one_r <= one_nxt;
			two_r <= two_nxt;
		end
	end

	assign status_one = one_r;
	assign status_two = two_r;

	parity_sticky_a: assert property (@(posedge mclk) disable iff (!reset_n)
		one_r[`ONE_PARITY] && !parity_clear |=> one_r[`ONE_PARITY])
		else $error("parity flag dropped without count clear");

	parity_set_a: assert property (@(posedge mclk) disable iff (!reset_n)
		parity_over |=> one_r[`ONE_PARITY])
		else $error("parity flag not set over limit");

	lock_change_a: assert property (@(posedge mclk) disable iff (!reset_n)
		receiver_locked != one_r[`ONE_LOCK] |=> one_r[`ONE_LOCK_CHG])
		else $error("lock change not flagged");

	event_wins_a: assert property (@(posedge mclk) disable iff (!reset_n)
		encode_err_evt && clear_two |=> two_r[`TWO_ENCODE_ERR])
		else $error("event lost against clear");

	unstable_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
		two_r[`TWO_LEN_UNSTABLE] && !clear_two |=> two_r[`TWO_LEN_UNSTABLE])
		else $error("unstable flag dropped without read");

	count_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
		clear_two && !cnt_chg_evt |=> !two_r[`TWO_CNT_CHG])
		else $error("line count flag not cleared by read");

	no_clock_a: assert property (@(posedge mclk) disable iff (!reset_n)
		freq_below_limit |=> two_r[`TWO_NO_CLOCK])
		else $error("no-clock flag missing");

endmodule : port_flag_bank

`default_nettype wire

// ### test/host_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_model
	import rx_status_pkg::*;
(
	input  wire logic         mclk,
	input  wire status_byte_t rd_data_r,
	input  wire logic         rd_valid_r,
	output var  port_idx_t    port_select,
	output var  logic         rd_strobe,
	output var  logic [7:0]   rd_addr
);
	// Quiet bus from time zero
	initial begin
		port_select = 2'h0;
		rd_strobe = 1'b0;
		rd_addr = 8'h00;
	end

	// One byte read, one-cycle strobe; error limit setup assumed above one
	task automatic read(input logic [7:0] addr, input port_idx_t port,
		output status_byte_t d);
		@(negedge mclk);
		port_select = port; // Page picked with the request
		rd_addr = addr;
		rd_strobe = 1'b1;
		@(negedge mclk);
		rd_strobe = 1'b0;
		rd_addr = ~addr; // No stale address once released
		d = (rd_valid_r === 1'b1) ? rd_data_r : 8'hxx;
	endtask : read

	// Two reads back to back, strobe held across both taking edges
	task automatic read_twice(input logic [7:0] addr, input port_idx_t port,
		output status_byte_t d1, output status_byte_t d2);
		@(negedge mclk);
		port_select = port;
		rd_addr = addr;
		rd_strobe = 1'b1;
		@(negedge mclk);
		d1 = (rd_valid_r === 1'b1) ? rd_data_r : 8'hxx;
		@(negedge mclk);
		rd_strobe = 1'b0;
		rd_addr = ~addr;
		d2 = (rd_valid_r === 1'b1) ? rd_data_r : 8'hxx;
	endtask : read_twice
endmodule : host_model

`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rx_status_params.svh"

module tb_top
	import rx_status_pkg::*;
;
	logic         mclk = 1'b0;
	logic         reset_n = 1'b0;
	port_idx_t    port_select;
	logic         rd_strobe;
	logic [7:0]   rd_addr;
	status_byte_t rd_data_r;
	status_byte_t got;
	status_byte_t got2;
	logic         rd_valid_r;
	port_vec_t    receiver_locked, pass_ok, parity_over, parity_clear;
	port_vec_t    unstable_evt, len_chg_evt, encode_err_evt, buf_overflow_evt;
	port_vec_t    camera_err, frequency_stable_flag, freq_below_limit, cnt_chg_evt;
	port_vec_t    crc_err_evt, seq_err_evt;
	int           num_errors = 0;
	int           n_compared = 0;

	// 20 MHz core clock
	always #25 mclk = ~mclk;

	rx_port_status_flags rx_port_status_flags_i (.mclk, .reset_n,
		.port_select, .rd_strobe, .rd_addr, .receiver_locked, .pass_ok,
		.parity_over, .parity_clear, .unstable_evt, .len_chg_evt,
		.encode_err_evt, .buf_overflow_evt, .camera_err, .frequency_stable_flag,
		.freq_below_limit, .cnt_chg_evt, .crc_err_evt, .seq_err_evt,
		.rd_data_r, .rd_valid_r);

	host_model host_model_i (.mclk, .rd_data_r, .rd_valid_r, .port_select,
		.rd_strobe, .rd_addr);

	task automatic chk(input status_byte_t g, input status_byte_t e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic rd(input logic [7:0] a, input port_idx_t p,
		input status_byte_t e);
		host_model_i.read(a, p, got);
		chk(got, e);
	endtask : rd

	// Event pulses last exactly one cycle
	task automatic end_pulse();
		@(negedge mclk);
		{parity_clear, parity_over, unstable_evt, len_chg_evt} = 16'h0000;
		{encode_err_evt, buf_overflow_evt, cnt_chg_evt} = 12'h000;
		{crc_err_evt, seq_err_evt} = 8'h00;
	endtask : end_pulse

	task automatic report_and_stop();
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	// Whole run is about 65 cycles; give it about thirty times that
	initial begin
		#(50 * 2000);
		num_errors++;
		report_and_stop();
	end

	initial begin
		{receiver_locked, pass_ok, camera_err, frequency_stable_flag} = 16'h0000;
		freq_below_limit = 4'h0;
		end_pulse();
		repeat (20) @(negedge mclk);
		reset_n = 1'b1;
		rd(`STS_TWO_OFS, 2'h0, 8'h00);
		rd(`STS_ONE_OFS, 2'h2, 8'h80);
		// Level inputs on port 1 only
		{receiver_locked, pass_ok, camera_err, frequency_stable_flag} = 16'h2222;
		freq_below_limit = 4'h2;
		repeat (3) @(negedge mclk);
		rd(`STS_ONE_OFS, 2'h1, 8'h53);
		rd(`STS_ONE_OFS, 2'h0, 8'h00);
		rd(`STS_ONE_OFS, 2'h1, 8'h43);
		rd(`STS_TWO_OFS, 2'h1, 8'h0e);
		// Drop on the shown port, read one edge later
		{receiver_locked, pass_ok, camera_err} = 12'h000;
		freq_below_limit = 4'h0;
		rd(`STS_ONE_OFS, 2'h1, 8'h50);
		rd(`STS_TWO_OFS, 2'h1, 8'h04);
		rd(8'h4f, 2'h2, 8'h00);
		// Every clear-on-read event of port 2's second register, read one edge later
		{unstable_evt, len_chg_evt, encode_err_evt} = 12'h444;
		{buf_overflow_evt, cnt_chg_evt} = 8'h44;
		fork
			host_model_i.read(`STS_TWO_OFS, 2'h2, got);
			end_pulse();
		join
		chk(got, 8'hf1);
		rd(`STS_TWO_OFS, 2'h2, 8'h00);
		// Parity flag is sticky across reads
		rd(`STS_ONE_OFS, 2'h3, 8'hc0);
		parity_over = 4'h8;
		fork
			host_model_i.read(`STS_ONE_OFS, 2'h3, got);
			end_pulse();
		join
		chk(got, 8'hc4);
		rd(`STS_ONE_OFS, 2'h3, 8'hc4);
		parity_clear = 4'h8;
		end_pulse();
		rd(`STS_ONE_OFS, 2'h3, 8'hc0);
		{crc_err_evt, seq_err_evt} = 8'h11;
		end_pulse();
		rd(`STS_ONE_OFS, 2'h0, 8'h28);
		rd(`STS_ONE_OFS, 2'h0, 8'h00);
		// Event lands on the very edge that takes the read
		fork
			host_model_i.read(`STS_TWO_OFS, 2'h0, got);
			begin
				@(negedge mclk);
				len_chg_evt = 4'h1;
				end_pulse();
			end
		join
		chk(got, 8'h00);
		// Back-to-back reads: the second sees the first one's clear
		host_model_i.read_twice(`STS_TWO_OFS, 2'h0, got, got2);
		chk(got, 8'h40);
		chk(got2, 8'h00);
		report_and_stop();
	end
endmodule : tb_top

`default_nettype wire
